// File: logic/hspwm_pkg.sv
// package of the host sdram page window map: register map, field layout,
// host window placement and register decode helpers.
// assumes a 32-bit apb with one aligned word per register (byte address = 4 * index).
package hspwm_pkg;

    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam logic [11:0] HSPWM_WIN0_IDX = 12'h030;
    localparam logic [11:0] HSPWM_WIN1_IDX = 12'h032;
    localparam logic [11:0] HSPWM_WIN2_IDX = 12'h034;
    localparam logic [11:0] HSPWM_WIN3_IDX = 12'h036;
    localparam logic [11:0] HSPWM_RSVD0_IDX = 12'h02C;
    localparam logic [11:0] HSPWM_RSVD1_IDX = 12'h02E;
    localparam logic [11:0] HSPWM_STATUS_IDX = 12'h046;
    localparam int HSPWM_PADDR_W = 14;
    localparam logic [13:0] HSPWM_WIN0_ADDR = {HSPWM_WIN0_IDX, 2'b00};
    localparam logic [13:0] HSPWM_WIN1_ADDR = {HSPWM_WIN1_IDX, 2'b00};
    localparam logic [13:0] HSPWM_WIN2_ADDR = {HSPWM_WIN2_IDX, 2'b00};
    localparam logic [13:0] HSPWM_WIN3_ADDR = {HSPWM_WIN3_IDX, 2'b00};
    localparam logic [13:0] HSPWM_RSVD0_ADDR = {HSPWM_RSVD0_IDX, 2'b00};
    localparam logic [13:0] HSPWM_RSVD1_ADDR = {HSPWM_RSVD1_IDX, 2'b00};
    localparam logic [13:0] HSPWM_STATUS_ADDR = {HSPWM_STATUS_IDX, 2'b00};

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int HSPWM_BASE_LSB = 2;
    localparam int HSPWM_BASE_MSB = 9;
    localparam int HSPWM_BASE_W = 8;
    localparam logic [7:0] HSPWM_BASE_RST = 8'h00;
    localparam int HSPWM_ST_WIN_LSB = 0;
    localparam int HSPWM_ST_HIT_BIT = 2;
    localparam int HSPWM_ST_MISS_BIT = 8;
    localparam int HSPWM_ST_BUSY_BIT = 9;

    // ************************************************************
    // host window placement
    // ************************************************************
    localparam int HSPWM_OFS_W = 18;
    localparam int HSPWM_SDRAM_W = 26;
    localparam int HSPWM_HOST_MIN_W = 21;
    localparam logic [31:0] HSPWM_WIN_FIRST = 32'h0010_0000;
    localparam logic [31:0] HSPWM_WIN_LAST = 32'h001F_FFFF;

    // ************************************************************
    // register select codes
    // ************************************************************
    localparam logic [2:0] HSPWM_SEL_STATUS = 3'h4;
    localparam logic [2:0] HSPWM_SEL_RSVD = 3'h5;
    localparam logic [2:0] HSPWM_SEL_NONE = 3'h7;

    // window registers give codes 0 to 3, the rest as above
    function automatic logic [2:0] hspwm_reg_sel(input logic [13:0] addr);
        logic [2:0] sel;
        sel = HSPWM_SEL_NONE;
        case (addr)
            HSPWM_WIN0_ADDR: sel = 3'h0;
            HSPWM_WIN1_ADDR: sel = 3'h1;
            HSPWM_WIN2_ADDR: sel = 3'h2;
            HSPWM_WIN3_ADDR: sel = 3'h3;
            HSPWM_STATUS_ADDR: sel = HSPWM_SEL_STATUS;
            HSPWM_RSVD0_ADDR: sel = HSPWM_SEL_RSVD;
            HSPWM_RSVD1_ADDR: sel = HSPWM_SEL_RSVD;
            default: sel = HSPWM_SEL_NONE;
        endcase
        return sel;
    endfunction

    // {hit, window index} of a host address
    function automatic logic [2:0] hspwm_win_of(input logic [31:0] addr);
        logic hit;
        hit = (addr >= HSPWM_WIN_FIRST) && (addr <= HSPWM_WIN_LAST);
        return {hit, addr[HSPWM_OFS_W+1:HSPWM_OFS_W]};
    endfunction

endpackage

// File: logic/hspwm_xlate.sv
// address translator of the host sdram page window map: picks the window of
// a host address and forms the sdram address from that window's page base.
// assumes the page bases are held stable by the register file around it.
`timescale 1ns/10ps
module hspwm_xlate #(
    parameter int HADDR_W = 21
) (
    // host side
    input wire logic [HADDR_W-1:0] host_addr,
    // page bases, window 3 in the top byte
    input wire logic [4*hspwm_pkg::HSPWM_BASE_W-1:0] page_base,
    // result
    output logic hit,
    output logic [1:0] win,
    output logic [hspwm_pkg::HSPWM_SDRAM_W-1:0] sdram_addr
);
    import hspwm_pkg::*;

    logic [31:0] wide_addr;
    logic [2:0] win_code;
    logic [HSPWM_BASE_W-1:0] sel_base;

    // refused at elaboration: the window decode needs at least bits 20-0
    if (HADDR_W < HSPWM_HOST_MIN_W || HADDR_W > 32) begin : g_bad_haddr_w
        $error("host address width out of range");
    end

    assign wide_addr = 32'(host_addr);
    assign win_code = hspwm_win_of(wide_addr);
    assign hit = win_code[2];
    assign win = win_code[1:0];
    assign sel_base = page_base[win*HSPWM_BASE_W +: HSPWM_BASE_W];
    // page bits from the base, offset bits straight from the host
    assign sdram_addr = {sel_base, wide_addr[HSPWM_OFS_W-1:0]};
endmodule

// File: logic/hspwm_top.sv
// host sdram page window map: four fixed host windows redirected onto
// programmable 256k-byte sdram pages, with an apb register file.
// assumes one clock, a host that holds its request until host_ready, and an
// sdram path that holds sdram_ready low while it cannot take a request.
`timescale 1ns/10ps
module hspwm_top #(
    parameter int HADDR_W = 21
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hspwm_pkg::HSPWM_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host memory request
    input wire logic host_valid,
    input wire logic host_write,
    input wire logic [HADDR_W-1:0] host_addr,
    output logic host_ready,
    output logic host_miss,
    // sdram memory request
    output logic sdram_valid,
    output logic sdram_write,
    output logic [hspwm_pkg::HSPWM_SDRAM_W-1:0] sdram_addr,
    input wire logic sdram_ready
);
    import hspwm_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [3:0][HSPWM_BASE_W-1:0] base;
        logic out_valid;
        logic out_write;
        logic [HSPWM_SDRAM_W-1:0] out_addr;
        logic miss;
        logic miss_seen;
        logic last_hit;
        logic [1:0] last_win;
        logic [31:0] rdata;
    } hspwm_state_s;

    hspwm_state_s cur;
    hspwm_state_s next_cur;

    logic x_hit;
    logic [1:0] x_win;
    logic [HSPWM_SDRAM_W-1:0] x_addr;
    logic [2:0] sel;
    logic setup_ph;
    logic access_ph;
    logic wr_take;
    logic host_take;
    logic slot_free;
    logic [31:0] rd_word;
    logic [HSPWM_BASE_W-1:0] wr_base;
    logic stat_clr;

    // ************************************************************
    // parameter check
    // ************************************************************
    if (HADDR_W < HSPWM_HOST_MIN_W || HADDR_W > 32) begin : g_bad_haddr_w
        $error("host address width out of range");
    end

    // ************************************************************
    // window translation
    // ************************************************************
    hspwm_xlate #(
        .HADDR_W(HADDR_W)
    ) u_xlate (
        .host_addr(host_addr),
        .page_base(cur.base),
        .hit(x_hit),
        .win(x_win),
        .sdram_addr(x_addr)
    );

    // ************************************************************
    // apb decode
    // ************************************************************
    assign sel = hspwm_reg_sel(paddr);
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = access_ph && (sel == HSPWM_SEL_NONE);
    // reserved locations answer without error but never store
    assign wr_take = access_ph && pwrite && (sel[2] == 1'b0);
    // the status word only takes a clear of its sticky miss bit
    assign stat_clr = access_ph && pwrite && (sel == HSPWM_SEL_STATUS) && pstrb[1]
        && pwdata[HSPWM_ST_MISS_BIT];
    assign prdata = cur.rdata;
    assign wr_base = pwdata[HSPWM_BASE_MSB:HSPWM_BASE_LSB];

    always_comb begin
        rd_word = 32'h0000_0000;
        case (sel)
            3'h0, 3'h1, 3'h2, 3'h3: begin
                // only bits 9-2 exist, the rest read zero
                rd_word[HSPWM_BASE_MSB:HSPWM_BASE_LSB] = cur.base[sel[1:0]];
            end
            HSPWM_SEL_STATUS: begin
                rd_word[HSPWM_ST_WIN_LSB +: 2] = cur.last_win;
                rd_word[HSPWM_ST_HIT_BIT] = cur.last_hit;
                rd_word[HSPWM_ST_MISS_BIT] = cur.miss_seen;
                rd_word[HSPWM_ST_BUSY_BIT] = cur.out_valid;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // host path
    // ************************************************************
    // one request slot; a stalled sdram path stalls host requests that hit a window, misses are still taken
    assign slot_free = !cur.out_valid || sdram_ready;
    assign host_ready = x_hit ? slot_free : 1'b1;
    assign host_take = host_valid && host_ready;
    assign sdram_valid = cur.out_valid;
    assign sdram_write = cur.out_write;
    assign sdram_addr = cur.out_addr;
    assign host_miss = cur.miss;

    always_comb begin
        next_cur = cur;
        next_cur.miss = 1'b0;
        if (setup_ph) begin
            // read data is caught in the setup cycle, ready for the access edge
            next_cur.rdata = rd_word;
        end
        if (stat_clr) begin
            next_cur.miss_seen = 1'b0;
        end
        if (wr_take && sel[2] == 1'b0) begin
            // bits 9-8 sit in lane 1, bits 7-2 in lane 0; other bits are dropped
            if (pstrb[0]) begin
                next_cur.base[sel[1:0]][5:0] = wr_base[5:0];
            end
            if (pstrb[1]) begin
                next_cur.base[sel[1:0]][7:6] = wr_base[7:6];
            end
        end
        if (cur.out_valid && sdram_ready) begin
            next_cur.out_valid = 1'b0;
        end
        if (host_take) begin
            if (x_hit) begin
                // window pick and page base selection, per window
                next_cur.out_valid = 1'b1;
                next_cur.out_addr = x_addr;
                next_cur.out_write = host_write;
                next_cur.last_win = x_win;
                next_cur.last_hit = 1'b1;
            end else begin
                // outside the windows: not redirected, only reported
                next_cur.miss = 1'b1;
                next_cur.last_hit = 1'b0;
                // a new miss beats a clear in the same cycle
                next_cur.miss_seen = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence host_in_win(logic [31:0] lo, logic [31:0] hi);
        host_valid && host_ready && (32'(host_addr) >= lo) && (32'(host_addr) <= hi);
    endsequence

    sequence write_base0;
        psel && penable && pwrite && paddr == HSPWM_WIN0_ADDR && pstrb[1:0] == 2'b11;
    endsequence

    sequence host_take_hit;
        host_valid && host_ready && x_hit;
    endsequence

    sequence host_take_miss;
        host_valid && host_ready && !x_hit;
    endsequence

    sequence status_clear;
        psel && penable && pwrite && sel == HSPWM_SEL_STATUS && pstrb[1]
            && pwdata[HSPWM_ST_MISS_BIT];
    endsequence

    win0_map_a: assert property (
        host_in_win(32'h0010_0000, 32'h0013_FFFF) |=> sdram_valid
            && sdram_addr[25:18] == $past(cur.base[0])
            && sdram_addr[17:0] == $past(host_addr[17:0]))
        else $error("window 0 redirect wrong");

    win1_map_a: assert property (
        host_in_win(32'h0014_0000, 32'h0017_FFFF) |=> sdram_addr[25:18] == $past(cur.base[1]))
        else $error("window 1 redirect wrong");

    win2_map_a: assert property (
        host_in_win(32'h0018_0000, 32'h001B_FFFF) |=> sdram_addr[25:18] == $past(cur.base[2]))
        else $error("window 2 redirect wrong");

    win3_map_a: assert property (
        host_in_win(32'h001C_0000, 32'h001F_FFFF) |=> sdram_addr[25:18] == $past(cur.base[3]))
        else $error("window 3 redirect wrong");

    base_write_a: assert property (
        write_base0 |=> cur.base[0] == $past(pwdata[9:2]))
        else $error("base readback mismatch");

    offset_pass_a: assert property (
        host_valid && host_ready && x_hit |=> sdram_addr[17:0] == $past(host_addr[17:0]))
        else $error("window offset not passed");

    reset_zero_a: assert property (
        $rose(presetn) |-> cur.base == '0)
        else $error("base not zero after reset");

    rsvd_ignore_a: assert property (
        psel && penable && sel == HSPWM_SEL_RSVD |=> cur.base == $past(cur.base))
        else $error("reserved write changed state");

    unused_zero_a: assert property (
        psel && !penable && sel[2] == 1'b0 |=> prdata[15:10] == 6'h00 && prdata[1:0] == 2'b00)
        else $error("unused base bits not zero");

    stall_hold_a: assert property (
        sdram_valid && !sdram_ready |=> sdram_valid && $stable(sdram_addr))
        else $error("sdram request dropped under stall");

    miss_flag_a: assert property (
        host_valid && !x_hit |=> host_miss ##1 !host_miss || $past(host_valid))
        else $error("miss pulse wrong");

    write_dir_a: assert property (
        host_take_hit |=> sdram_write == $past(host_write))
        else $error("sdram direction wrong");

    last_win_a: assert property (
        host_take_hit |=> cur.last_hit && cur.last_win == $past(host_addr[19:18]))
        else $error("last window wrong");

    no_forward_a: assert property (
        host_take_miss ##0 !sdram_valid |=> !sdram_valid)
        else $error("miss forwarded to sdram");

    stall_block_a: assert property (
        sdram_valid && !sdram_ready && x_hit |-> !host_ready)
        else $error("host taken into full slot");

    slot_release_a: assert property (
        sdram_valid && sdram_ready && !(host_valid && host_ready && x_hit) |=> !sdram_valid)
        else $error("sdram slot not released");

    base_hold_a: assert property (
        !(psel && penable && pwrite && sel[2] == 1'b0) |=> cur.base == $past(cur.base))
        else $error("base changed without write");

    read_base_a: assert property (
        psel && !penable && sel[2] == 1'b0 |=> prdata[9:2] == $past(cur.base[sel[1:0]]))
        else $error("base read data wrong");

    miss_set_a: assert property (
        host_take_miss |=> cur.miss_seen)
        else $error("sticky miss not set");

    miss_hold_a: assert property (
        cur.miss_seen && !(psel && penable && pwrite && sel == HSPWM_SEL_STATUS)
            |=> cur.miss_seen)
        else $error("sticky miss lost");

    miss_clear_a: assert property (
        status_clear ##0 !(host_valid && !x_hit) |=> !cur.miss_seen)
        else $error("sticky miss not cleared");

    reset_idle_a: assert property (
        $rose(presetn) |-> !sdram_valid && !host_miss && prdata == 32'h0000_0000)
        else $error("outputs not idle after reset");
endmodule

// File: tb/hspwm_sdram_model.sv
// sdram path stand-in for the page window map bench: accepts or stalls requests.
// assumes the design holds its sdram request until sdram_ready is high at an edge.
`timescale 1ns/10ps
module hspwm_sdram_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic stall,
    output int taken,
    // sdram request
    input wire logic sdram_valid,
    input wire logic [hspwm_pkg::HSPWM_SDRAM_W-1:0] sdram_addr,
    output logic sdram_ready
);
    import hspwm_pkg::*;
    // a stalled path keeps ready low so the single request slot stays full
    assign sdram_ready = ~stall;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken <= 0;
        end else if (sdram_valid && sdram_ready) begin
            taken <= taken + 1;
        end
    end
endmodule

// File: tb/test_host_sdram_page_window_map.sv
// self-checking bench of the host sdram page window map.
// assumes a zero-wait apb slave and the sdram model beside the design.
`timescale 1ns/10ps
module test_host_sdram_page_window_map;
    import hspwm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic host_valid, host_write, host_ready, host_miss, stall;
    logic [20:0] host_addr;
    logic sdram_valid, sdram_write, sdram_ready;
    logic [25:0] sdram_addr;
    int miscompares, num_checks, taken;
    logic [13:0] wadr [4] = '{HSPWM_WIN0_ADDR, HSPWM_WIN1_ADDR, HSPWM_WIN2_ADDR, HSPWM_WIN3_ADDR};
    logic [7:0] pg [4] = '{8'h81, 8'h42, 8'h24, 8'hFF};

    hspwm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_valid(host_valid), .host_write(host_write),
        .host_addr(host_addr), .host_ready(host_ready), .host_miss(host_miss),
        .sdram_valid(sdram_valid), .sdram_write(sdram_write), .sdram_addr(sdram_addr),
        .sdram_ready(sdram_ready));
    hspwm_sdram_model partner (.pclk(pclk), .presetn(presetn), .stall(stall), .taken(taken),
        .sdram_valid(sdram_valid), .sdram_addr(sdram_addr), .sdram_ready(sdram_ready));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // an idle edge first, so psel is never lowered and raised in one time step
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the answer is taken at the rising edge that sees pready high
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic host_req(input logic [20:0] a, input logic w);
        @(posedge pclk);
        host_valid <= 1'b1;
        host_addr <= a;
        host_write <= w;
        do @(posedge pclk); while (host_ready !== 1'b1);
        host_valid <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic reset_values;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, wadr[i], 32'h0, r, e);
            check("base after reset", r, 32'h0);
        end
    endtask

    // page values written with ones in all bits outside 9-2, only bits 9-2 may keep what was written
    task automatic base_fields;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++) apb(1'b1, wadr[i], {22'h3FFFFF, pg[i], 2'b11}, r, e);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, wadr[i], 32'h0, r, e);
            check("base readback", r, {22'h0, pg[i], 2'b00});
            check("base pslverr", e, 32'h0);
        end
    endtask

    // first and last byte of every window, writes and reads alternating
    task automatic window_map;
        logic [20:0] a;
        for (int i = 0; i < 8; i++) begin
            a = 21'h100000 + 21'(i / 2) * 21'h40000 + ((i % 2) ? 21'h3FFFF : 21'h0);
            host_req(a, i[0]);
            @(negedge pclk);
            check("sdram valid", sdram_valid, 32'h1);
            check("sdram addr", sdram_addr, {pg[i / 2], a[17:0]});
            check("sdram write", sdram_write, i[0]);
        end
    endtask

    // just below the windows and at address zero: flagged, never forwarded
    task automatic outside_windows;
        logic [20:0] a [2] = '{21'h0FFFFF, 21'h000000};
        for (int i = 0; i < 2; i++) begin
            host_req(a[i], 1'b0);
            @(negedge pclk);
            check("miss pulse", host_miss, 32'h1);
            check("no sdram request", sdram_valid, 32'h0);
        end
    endtask

    // second request must wait while the first still sits in the slot
    task automatic stalled_path;
        int t0;
        t0 = taken;
        @(posedge pclk);
        stall <= 1'b1;
        host_req(21'h1C0004, 1'b1);
        // one edge apart, so host_valid is not lowered and raised in one time step
        @(posedge pclk);
        host_valid <= 1'b1;
        host_addr <= 21'h140008;
        host_write <= 1'b0;
        repeat (3) begin
            @(negedge pclk);
            check("stalled host ready", host_ready, 32'h0);
            check("held sdram addr", sdram_addr, {pg[3], 18'h00004});
        end
        @(posedge pclk);
        stall <= 1'b0;
        do @(posedge pclk); while (host_ready !== 1'b1);
        host_valid <= 1'b0;
        @(negedge pclk);
        check("second sdram addr", sdram_addr, {pg[1], 18'h00008});
        @(negedge pclk);
        check("both taken", taken - t0, 32'h2);
    endtask

    // reserved places are only read, never written; unmapped ones give an error
    task automatic odd_addresses;
        logic [31:0] r;
        logic e;
        apb(1'b0, HSPWM_RSVD0_ADDR, 32'h0, r, e);
        check("reserved read", r, 32'h0);
        apb(1'b0, 14'h0004, 32'h0, r, e);
        check("unmapped pslverr", e, 32'h1);
        apb(1'b0, wadr[2], 32'h0, r, e);
        check("base kept", r, {22'h0, pg[2], 2'b00});
        // status: window 1 taken last, a miss seen earlier, slot empty
        apb(1'b0, HSPWM_STATUS_ADDR, 32'h0, r, e);
        check("status word", r, 32'h0000_0105);
        apb(1'b1, HSPWM_STATUS_ADDR, 32'h0000_0100, r, e);
        apb(1'b0, HSPWM_STATUS_ADDR, 32'h0, r, e);
        check("status after clear", r, 32'h0000_0005);
    endtask

    // ************************************************************
    // clock, reset, sequence and watchdog
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        miscompares = 0;
        num_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, host_valid, host_write, stall} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        host_addr = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        base_fields();
        window_map();
        outside_windows();
        stalled_path();
        odd_addresses();
        print_verdict();
    end

    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
endmodule
